//--- verilog/phy_counter_crossover_regs.v
// management register bank: jabber counter, led/jabber control, mdi/mdi-x crossover
`timescale 1ns/10ps
`include "phy_regs_consts.vh"

module phy_counter_crossover_regs #(
   parameter TICKS_PER_MS = 1000
) (
   // clock and reset
   input wire i_clock,
   input wire i_arst_n,
   // avalon-mm slave
   input wire [`ADDR_W+1:0] i_address,
   input wire i_read,
   input wire i_write,
   input wire [31:0] i_writedata,
   input wire [3:0] i_byteenable,
   output reg [31:0] o_readdata,
   output wire o_waitrequest,
   output wire [1:0] o_response,
   // phy status inputs, asynchronous to i_clock
   input wire i_tx_jabber,
   input wire i_rx_jabber_100,
   input wire i_carrier_sense,
   input wire i_activity,
   input wire i_link,
   input wire i_speed_100,
   input wire i_collision,
   input wire i_energy_ok,
   input wire i_new_mode,
   // phy outputs
   output reg o_carrier_sense,
   output reg o_activity_led_n,
   output reg o_link_led_n,
   output reg o_mdix,
   output reg o_probe_map
);

   localparam [2:0] ST_IDLE = 3'b001;
   localparam [2:0] ST_ACK = 3'b010;
   localparam [2:0] ST_DONE = 3'b100;
   localparam [3:0] XO_RESOLVED = 4'b0001;
   localparam [3:0] XO_WAIT = 4'b0010;
   localparam [3:0] XO_SWAP = 4'b0100;
   localparam [3:0] XO_MANUAL = 4'b1000;
   localparam [31:0] TICK_FULL = `TICK_CYCLES;
   localparam [5:0] TICK_CNT = TICK_FULL[5:0];
   localparam [31:0] SLOT_BASE_TICKS = `SLOT_BASE_MS * TICKS_PER_MS;
   localparam [31:0] SLOT_SPAN_TICKS = (`SLOT_MAX_MS - `SLOT_BASE_MS) * TICKS_PER_MS;

   // three-stage synchronisers for all pin inputs
   localparam NSYNC = 9;
   wire [NSYNC-1:0] pins = {i_new_mode, i_energy_ok, i_collision, i_speed_100, i_link,
                            i_activity, i_carrier_sense, i_rx_jabber_100, i_tx_jabber};
   reg [NSYNC-1:0] s1_q;
   reg [NSYNC-1:0] s2_q;
   reg [NSYNC-1:0] s3_q;
   // filtered level, the only copy the rest of the block reads
   reg [NSYNC-1:0] st_q;
   genvar g;
   generate
      for (g = 0; g < NSYNC; g = g + 1) begin : g_sync
         always @(posedge i_clock or negedge i_arst_n) begin
            if (!i_arst_n) begin
               s1_q[g] <= 1'b0;
               s2_q[g] <= 1'b0;
               s3_q[g] <= 1'b0;
               st_q[g] <= 1'b0;
            end else begin
               s1_q[g] <= pins[g];
               s2_q[g] <= s1_q[g];
               s3_q[g] <= s2_q[g];
               // a change counts only once stages two and three agree
               if (s2_q[g] == s3_q[g]) begin
                  st_q[g] <= s3_q[g];
               end
            end
         end
      end
   endgenerate
   wire tx_jab = st_q[0];
   wire rx_jab = st_q[1];
   wire crs = st_q[2];
   wire act = st_q[3];
   wire lnk = st_q[4];
   wire spd = st_q[5];
   wire col = st_q[6];
   wire energy = st_q[7];
   wire new_mode = st_q[8];

   function is_reg;
      input [`ADDR_W+1:0] a;
      input [`ADDR_W-1:0] idx;
      begin
         is_reg = (a[1:0] == 2'b00) && (a[`ADDR_W+1:2] == idx);
      end
   endfunction

   // bus handshake: one wait cycle, answer at second edge
   reg [2:0] bus_q;
   wire req = i_read | i_write;
   assign o_waitrequest = req & (bus_q != ST_ACK);
   assign o_response = 2'b00;
   // read data are copied on the request edge so they stand while waitrequest is low
   wire rd_cap = i_read & (bus_q == ST_IDLE);
   wire wr_acc = i_write & (bus_q == ST_ACK);
   wire hit_jab = is_reg(i_address, `IDX_TX_JABBER_EVENT_COUNT);
   wire hit_spc = is_reg(i_address, `IDX_PHY_SPECIAL_CONTROL);
   wire hit_xo = is_reg(i_address, `IDX_CROSSOVER_CONTROL);
   wire hit_stat = is_reg(i_address, `IDX_LINK_STATUS_IN);

   always @(posedge i_clock or negedge i_arst_n) begin
      if (!i_arst_n) begin
         bus_q <= ST_IDLE;
      end else begin
         case (bus_q)
            ST_IDLE: begin
               if (req) begin
                  bus_q <= ST_ACK;
               end
            end
            ST_ACK: begin
               bus_q <= ST_DONE;
            end
            // dead state keeps a still-held request from being taken twice
            ST_DONE: begin
               bus_q <= ST_IDLE;
            end
            default: begin
               bus_q <= ST_IDLE;
            end
         endcase
      end
   end

   // jabber event counter
   reg [15:0] jab_cnt_q;
   reg tx_jab_d1_q;
   wire jab_evt = tx_jab & ~tx_jab_d1_q;
   // cleared on the edge that copies it, so no event slips in between
   wire jab_clr = rd_cap & hit_jab;
   always @(posedge i_clock or negedge i_arst_n) begin
      if (!i_arst_n) begin
         jab_cnt_q <= 16'h0000;
         tx_jab_d1_q <= 1'b0;
      end else begin
         tx_jab_d1_q <= tx_jab;
         if (jab_clr) begin
            // an event in the read cycle is kept, not lost
            jab_cnt_q <= jab_evt ? 16'h0001 : 16'h0000;
         end else if (jab_evt && jab_cnt_q != 16'hffff) begin
            jab_cnt_q <= jab_cnt_q + 16'h0001;
         end
      end
   end

   // special control and crossover control registers
   reg [5:0] spc_q;
   reg [7:0] xo_ctl_q;
   always @(posedge i_clock or negedge i_arst_n) begin
      if (!i_arst_n) begin
         spc_q <= 6'h00;
         xo_ctl_q <= 8'h00;
      end else if (wr_acc && i_byteenable[0]) begin
         // lane 0 carries every writable bit of both registers
         if (hit_spc) begin
            // bit 4 is read-only; reserved bits are not stored
            spc_q[5] <= i_writedata[`SPC_PROBE_MAP_BIT];
            spc_q[3:0] <= i_writedata[3:0];
         end
         if (hit_xo) begin
            xo_ctl_q[7:6] <= i_writedata[7:6];
            xo_ctl_q[3:0] <= i_writedata[3:0];
         end
      end
   end
   wire auto_en = xo_ctl_q[`XO_AUTO_BIT];
   wire manual_x = xo_ctl_q[`XO_MANUAL_BIT];
   wire rxj_dis = spc_q[`SPC_RX_JABBER_BIT];
   wire [2:0] led_sel = spc_q[2:0];

   // microsecond-scale tick enable for the slot timer
   // free running, so a slot may begin anywhere inside a tick
   reg [5:0] div_q;
   wire tick = (div_q == TICK_CNT - 6'h01);
   always @(posedge i_clock or negedge i_arst_n) begin
      if (!i_arst_n) begin
         div_q <= 6'h00;
      end else begin
         div_q <= tick ? 6'h00 : div_q + 6'h01;
      end
   end

   // slot length in ticks: 80 ms plus code/15 of the 25 ms span
   wire [31:0] slot_len = SLOT_BASE_TICKS +
      (SLOT_SPAN_TICKS * {28'h0000000, xo_ctl_q[3:0]}) / `SLOT_CODE_MAX;

   // crossover resolution: swap pairs each slot until energy/link is seen
   reg [3:0] xo_q;
   reg [31:0] slot_q;
   reg done_q;
   always @(posedge i_clock or negedge i_arst_n) begin
      if (!i_arst_n) begin
         xo_q <= XO_MANUAL;
         slot_q <= 32'h00000000;
         o_mdix <= 1'b0;
         done_q <= 1'b0;
      end else begin
         case (xo_q)
            XO_MANUAL: begin
               o_mdix <= manual_x;
               done_q <= 1'b0;
               slot_q <= 32'h00000000;
               if (auto_en) begin
                  xo_q <= XO_WAIT;
               end
            end
            XO_WAIT: begin
               done_q <= 1'b0;
               if (!auto_en) begin
                  xo_q <= XO_MANUAL;
               end else if (lnk || energy) begin
                  xo_q <= XO_RESOLVED;
               end else if (tick) begin
                  // first tick is partial; counting whole ticks keeps the slot at its minimum
                  if (slot_q >= slot_len) begin
                     xo_q <= XO_SWAP;
                  end else begin
                     slot_q <= slot_q + 32'h00000001;
                  end
               end
            end
            XO_SWAP: begin
               o_mdix <= ~o_mdix;
               slot_q <= 32'h00000000;
               xo_q <= XO_WAIT;
            end
            XO_RESOLVED: begin
               done_q <= 1'b1;
               if (!auto_en) begin
                  xo_q <= XO_MANUAL;
               end else if (!lnk && !energy) begin
                  done_q <= 1'b0;
                  slot_q <= 32'h00000000;
                  xo_q <= XO_WAIT;
               end
            end
            default: begin
               xo_q <= XO_MANUAL;
            end
         endcase
      end
   end

   // led mux, carrier sense gating, probe bit
   reg act_src;
   reg lnk_src;
   always @* begin
      case (led_sel)
         `LED_ACT_LINK: begin
            act_src = act;
            lnk_src = lnk;
         end
         `LED_SPD_COL: begin
            act_src = spd;
            lnk_src = col;
         end
         `LED_SPD_LINK: begin
            act_src = spd;
            lnk_src = lnk;
         end
         `LED_ACT_COL: begin
            act_src = act;
            lnk_src = col;
         end
         `LED_OFF_OFF: begin
            act_src = 1'b0;
            lnk_src = 1'b0;
         end
         `LED_OFF_ON: begin
            act_src = 1'b0;
            lnk_src = 1'b1;
         end
         `LED_ON_OFF: begin
            act_src = 1'b1;
            lnk_src = 1'b0;
         end
         default: begin
            act_src = 1'b1;
            lnk_src = 1'b1;
         end
      endcase
   end
   // led pins are active low: a one from the mux lights the lamp
   always @(posedge i_clock or negedge i_arst_n) begin
      if (!i_arst_n) begin
         o_activity_led_n <= 1'b1;
         o_link_led_n <= 1'b1;
         o_carrier_sense <= 1'b0;
         o_probe_map <= 1'b0;
      end else begin
         o_activity_led_n <= ~act_src;
         o_link_led_n <= ~lnk_src;
         o_carrier_sense <= crs & ~(rxj_dis & rx_jab & spd);
         // software is expected to keep this at zero
         o_probe_map <= spc_q[5];
      end
   end

   // read data, registered on the request edge and held through the answer
   always @(posedge i_clock or negedge i_arst_n) begin
      if (!i_arst_n) begin
         o_readdata <= 32'h00000000;
      end else if (rd_cap) begin
         if (hit_jab) begin
            o_readdata <= {16'h0000, jab_cnt_q};
         end else if (hit_spc) begin
            o_readdata <= {26'h0000000, spc_q[5], new_mode, spc_q[3:0]};
         end else if (hit_xo) begin
            // upper bytes are not stored and always read back as zero
            o_readdata <= {24'h000000, xo_ctl_q[7:6], o_mdix, done_q, xo_ctl_q[3:0]};
         end else if (hit_stat) begin
            o_readdata <= {23'h000000, st_q};
         end else begin
            o_readdata <= 32'h00000000;
         end
      end
   end

endmodule

//--- verilog/phy_regs_consts.vh
// register offsets, field positions and timing constants for the phy counter/crossover bank
`ifndef PHY_REGS_CONSTS_VH
`define PHY_REGS_CONSTS_VH
// register indices; byte address is four times the index
`define IDX_TX_JABBER_EVENT_COUNT 8'h19
`define IDX_PHY_SPECIAL_CONTROL 8'h1b
`define IDX_CROSSOVER_CONTROL 8'h1c
`define IDX_LINK_STATUS_IN 8'h1d
`define ADDR_W 8
// special control fields
`define SPC_PROBE_MAP_BIT 5
`define SPC_NEW_MODE_BIT 4
`define SPC_RX_JABBER_BIT 3
`define SPC_LED_SEL_MSB 2
`define SPC_RESET 16'h0000
// crossover control fields
`define XO_AUTO_BIT 7
`define XO_MANUAL_BIT 6
`define XO_STATUS_BIT 5
`define XO_DONE_BIT 4
`define XO_TIMER_MSB 3
`define XO_RESET 16'h0000
// led selector codes
`define LED_ACT_LINK 3'h0
`define LED_SPD_COL 3'h1
`define LED_SPD_LINK 3'h2
`define LED_ACT_COL 3'h3
`define LED_OFF_OFF 3'h4
`define LED_OFF_ON 3'h5
`define LED_ON_OFF 3'h6
`define LED_ON_ON 3'h7
// slot time: 80 ms at code 0, 105 ms at code 15, 5/3 ms per step
`define CLK_HZ 50000000
`define SLOT_BASE_MS 80
`define SLOT_MAX_MS 105
`define SLOT_CODE_MAX 15
// one tick per microsecond
`define TICK_US 1
`define TICK_CYCLES ((`CLK_HZ / 1000000) * `TICK_US)
`endif

//--- sim/phy_regs_assertions.sv
// concurrent checks on the ports of the phy counter/crossover register bank
`timescale 1ns/10ps
module phy_regs_checker (
   // clock, reset and bus
   input wire i_clock,
   input wire i_arst_n,
   input wire [9:0] i_address,
   input wire i_read,
   input wire i_write,
   input wire [31:0] i_writedata,
   input wire [31:0] o_readdata,
   input wire o_waitrequest,
   // phy side
   input wire i_tx_jabber,
   input wire i_rx_jabber_100,
   input wire i_carrier_sense,
   input wire i_speed_100,
   input wire o_carrier_sense,
   input wire o_activity_led_n,
   input wire o_link_led_n,
   input wire o_mdix
);
   wire rd_cnt = i_read && !o_waitrequest && i_address == 10'h064;
   wire rd_spc = i_read && !o_waitrequest && i_address == 10'h06c;
   wire rd_xo = i_read && !o_waitrequest && i_address == 10'h070;
   reg [7:0] xo_q;
   reg [3:0] spc_q;
   reg [3:0] quiet_q;
   reg clr_q;
   // shadow copies; quiet_q lets the input synchroniser drain first
   always @(posedge i_clock or negedge i_arst_n) begin
      if (!i_arst_n) begin
         xo_q <= 8'h00;
         spc_q <= 4'h0;
         quiet_q <= 4'h0;
         clr_q <= 1'b0;
      end else begin
         if (i_write && !o_waitrequest && i_address == 10'h070) xo_q <= i_writedata[7:0];
         if (i_write && !o_waitrequest && i_address == 10'h06c) spc_q <= i_writedata[3:0];
         quiet_q <= i_tx_jabber ? 4'h0 : quiet_q + {3'h0, quiet_q != 4'hf};
         clr_q <= i_tx_jabber ? 1'b0 : ((rd_cnt && quiet_q == 4'hf) ? 1'b1 : clr_q);
      end
   end
   default clocking cb @(posedge i_clock); endclocking
   default disable iff (!i_arst_n);
   AST_CNT_CLEARED: assert property (rd_cnt && clr_q |-> o_readdata == 32'h0)
      else $error("jabber count not cleared by earlier read");
   AST_SPC_READ: assert property (rd_spc |-> o_readdata[31:6] == 26'h0 && o_readdata[3:0] == spc_q)
      else $error("special control readback wrong");
   AST_XO_FIELDS: assert property (rd_xo |-> o_readdata[31:8] == 24'h0 && o_readdata[7:6] == xo_q[7:6] && o_readdata[3:0] == xo_q[3:0])
      else $error("crossover readback wrong");
   AST_XO_STATUS: assert property (rd_xo && !xo_q[7] |-> o_readdata[5] == o_mdix)
      else $error("crossover status bit differs from pair state");
   AST_XO_DONE_MANUAL: assert property (rd_xo && !xo_q[7] |-> !o_readdata[4])
      else $error("completion flag set in manual mode");
   AST_MANUAL_MDIX: assert property (!xo_q[7] && $stable(xo_q) |-> o_mdix == xo_q[6])
      else $error("manual crossover not followed");
   AST_LED_FIXED: assert property (spc_q[2] && $stable(spc_q) |-> o_activity_led_n == !spc_q[1] && o_link_led_n == !spc_q[0])
      else $error("fixed led levels wrong");
   AST_CRS_CUT: assert property ((spc_q[3] && i_rx_jabber_100 && i_speed_100) [*8] |-> !o_carrier_sense)
      else $error("carrier sense not cut during jabber");
   AST_CRS_PASS: assert property ((!spc_q[3] && i_carrier_sense) [*8] |-> o_carrier_sense)
      else $error("carrier sense blocked");
endmodule
bind phy_counter_crossover_regs phy_regs_checker i_checker (.i_clock(i_clock), .i_arst_n(i_arst_n),
   .i_address(i_address), .i_read(i_read), .i_write(i_write), .i_writedata(i_writedata),
   .o_readdata(o_readdata), .o_waitrequest(o_waitrequest), .i_tx_jabber(i_tx_jabber),
   .i_rx_jabber_100(i_rx_jabber_100), .i_carrier_sense(i_carrier_sense), .i_speed_100(i_speed_100),
   .o_carrier_sense(o_carrier_sense), .o_activity_led_n(o_activity_led_n), .o_link_led_n(o_link_led_n),
   .o_mdix(o_mdix));

//--- sim/testbench.sv
// self-checking bench for the phy counter/crossover register bank
`timescale 1ns/10ps
module testbench;
   logic i_clock = 1'b0, i_arst_n = 1'b0, read = 1'b0, write = 1'b0, tx_jab = 1'b0, rxj = 1'b0;
   logic crs = 1'b0, act = 1'b1, link = 1'b1, spd = 1'b0;
   logic col = 1'b0, energy = 1'b0, nmode = 1'b0;
   logic [9:0] address = 10'h000;
   logic [31:0] wdata = 32'h0, rdata, d;
   wire [31:0] o_readdata;
   wire o_waitrequest, o_carrier_sense, o_activity_led_n, o_link_led_n, o_mdix, o_probe_map;
   integer failures = 0, check_count = 0, cycles = 0, c;
   phy_counter_crossover_regs #(.TICKS_PER_MS(2)) i_phy_counter_crossover_regs (.i_clock(i_clock),
      .i_arst_n(i_arst_n), .i_address(address), .i_read(read), .i_write(write), .i_writedata(wdata),
      .i_byteenable(4'hf), .o_readdata(o_readdata), .o_waitrequest(o_waitrequest), .o_response(),
      .i_tx_jabber(tx_jab), .i_rx_jabber_100(rxj), .i_carrier_sense(crs), .i_activity(act), .i_link(link),
      .i_speed_100(spd), .i_collision(col), .i_energy_ok(energy), .i_new_mode(nmode),
      .o_carrier_sense(o_carrier_sense), .o_activity_led_n(o_activity_led_n), .o_link_led_n(o_link_led_n),
      .o_mdix(o_mdix), .o_probe_map(o_probe_map));
   always #10 i_clock = ~i_clock;
   task automatic print_verdict;
      $display("checks %0d mismatches %0d", check_count, failures);
      if (failures == 0 && check_count > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   always @(posedge i_clock) begin
      cycles = cycles + 1;
      // two auto slots of 105 and 80 ms at 100 cycles per ms dominate the run
      if (cycles == 40000) begin
         failures = failures + 1;
         print_verdict;
      end
   end
   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      check_count = check_count + 1;
      if (seen !== exp) begin
         failures = failures + 1;
         $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
      end
   endtask
   // one bus transfer; request held until waitrequest is seen low at an edge
   task automatic bus(input logic wr, input logic [9:0] a, input logic [31:0] wd);
      @(posedge i_clock);
      address <= a;
      wdata <= wd;
      read <= !wr;
      write <= wr;
      // waitrequest and read data are both taken at the same rising edge
      do @(posedge i_clock); while (o_waitrequest !== 1'b0);
      rdata = o_readdata;
      read <= 1'b0;
      write <= 1'b0;
   endtask
   task automatic t_reset;
      bus(0, 10'h070, 0); check("xo reset", rdata, 32'h0);
      bus(0, 10'h06c, 0); check("spc reset", rdata, 32'h0);
      bus(0, 10'h3fc, 0); check("unmapped", rdata, 32'h0);
      $display("test reset done");
   endtask
   task automatic t_jabber;
      repeat (3) begin
         @(posedge i_clock) tx_jab <= 1'b1;
         repeat (8) @(posedge i_clock);
         tx_jab <= 1'b0;
         repeat (8) @(posedge i_clock);
      end
      repeat (8) @(posedge i_clock);
      bus(0, 10'h064, 0); check("jabber count", rdata, 32'h3);
      repeat (20) @(posedge i_clock);
      bus(0, 10'h064, 0); check("jabber cleared", rdata, 32'h0);
      $display("test jabber done");
   endtask
   task automatic t_leds;
      logic [15:0] tbl = 16'b01_10_11_00_11_10_01_00;
      link <= 1'b0;
      col <= 1'b1;
      nmode <= 1'b1;
      for (c = 0; c < 8; c++) begin
         bus(1, 10'h06c, 32'hffff_ffd0 | c);
         repeat (8) @(posedge i_clock);
         check("leds", {o_activity_led_n, o_link_led_n}, tbl[15-2*c -: 2]);
         bus(0, 10'h06c, 0); check("spc read", rdata, c | 32'h10);
         check("probe map", o_probe_map, 1'b0);
      end
      link <= 1'b1;
      col <= 1'b0;
      $display("test leds done");
   endtask
   task automatic t_crs;
      crs <= 1'b1;
      rxj <= 1'b1;
      spd <= 1'b1;
      bus(1, 10'h06c, 32'h8);
      repeat (10) @(posedge i_clock);
      check("crs cut", o_carrier_sense, 1'b0);
      bus(1, 10'h06c, 32'h0);
      repeat (10) @(posedge i_clock);
      check("crs pass", o_carrier_sense, 1'b1);
      $display("test carrier done");
   endtask
   task automatic t_xo;
      bus(1, 10'h070, 32'h4f);
      repeat (4) @(posedge i_clock);
      check("mdix forced", o_mdix, 1'b1);
      bus(0, 10'h070, 0); check("xo manual x", rdata, 32'h6f);
      bus(1, 10'h070, 32'h0f);
      bus(0, 10'h070, 0); check("xo manual", rdata, 32'h0f);
      bus(1, 10'h070, 32'h80);
      repeat (20) @(posedge i_clock);
      bus(0, 10'h070, 0);
      d = rdata;
      check("xo auto", d & 32'hffdf, 32'h90);
      check("xo status", d[5], o_mdix);
      $display("test crossover done");
   endtask
   // auto crossover with no link: the pair swaps after one full slot
   task automatic t_slot(input logic [3:0] code, input integer ms, input logic x);
      integer n;
      n = 0;
      bus(1, 10'h070, {24'h000000, 4'h8, code});
      link <= 1'b0;
      do begin
         @(posedge i_clock);
         n = n + 1;
      end while (o_mdix !== x && n < 12000);
      check("slot min", n >= ms * 100, 1'b1);
      check("slot max", n <= ms * 100 + 100, 1'b1);
      bus(0, 10'h070, 0); check("xo resolving", rdata, {24'h000000, 2'b10, x, 1'b0, code});
      energy <= 1'b1;
      repeat (10) @(posedge i_clock);
      bus(0, 10'h070, 0); check("xo resolved", rdata, {24'h000000, 2'b10, x, 1'b1, code});
      link <= 1'b1;
      energy <= 1'b0;
      $display("test slot %0d ms done", ms);
   endtask
   initial begin
      repeat (2) @(posedge i_clock);
      i_arst_n <= 1'b1;
      t_reset;
      t_jabber;
      t_leds;
      t_crs;
      t_xo;
      t_slot(4'hf, 105, 1'b1);
      t_slot(4'h0, 80, 1'b0);
      print_verdict;
   end
endmodule
